// ---- design/rtc_alarm_pkg.sv ----
// Package with register layout, offsets and shared types of the alarm control block.
package rtc_alarm_pkg;
  localparam int          ADDR_W          = 20;
  localparam logic [19:0] CTRL_ONE_ADDR   = 20'hFFF9E;
  localparam logic [19:0] IRQ_STATUS_ADDR = 20'hFFFA0;
  localparam logic [19:0] IRQ_MASK_ADDR   = 20'hFFFA1;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  CTRL_FIXED_ZERO = 8'h24;
  localparam int          BIT_MATCH_EN    = 7;
  localparam int          BIT_IRQ_EN      = 6;
  localparam int          BIT_DETECTED    = 4;
  localparam int          BIT_PERIODIC    = 3;
  localparam int          BIT_WAIT_STAT   = 1;
  localparam int          BIT_WAIT_REQ    = 0;
  localparam int          EVT_ALARM       = 0;
  localparam int          EVT_PERIODIC    = 1;
  localparam int          EVT_W           = 2;
  localparam logic [1:0]  EVT_RESET       = 2'h0;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  wmask;
    logic        wr;
    logic        rd;
  } bus_req_t;
endpackage : rtc_alarm_pkg

// ---- design/rtc_flag_cell.sv ----
`timescale 1ns/10ps
// Sticky flag cell: hardware set wins over a software clear in the same cycle.
module rtc_flag_cell (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic setPulse,
  input  wire logic clrPulse,
  output logic      flag
);
  logic flag_reg;
  logic flag_next;

  always_comb
  begin
    flag_next = flag_reg;
    if (clrPulse)
      flag_next = 1'b0;
    if (setPulse)
      flag_next = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next;
  end

  assign flag = flag_reg;
endmodule : rtc_flag_cell

// ---- design/rtc_alarm_control.sv ----
`timescale 1ns/10ps
// Alarm control register of the calendar clock with interrupt status and mask.
module rtc_alarm_control (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic [19:0] busAddr,
  input  wire logic [7:0] busWdata,
  input  wire logic [7:0] busWmask,
  input  wire logic       busWrite,
  input  wire logic       busRead,
  output logic [7:0]      busRdata,
  input  wire logic       alarmMatch,
  input  wire logic       periodicEvent,
  input  wire logic       calendarTick,
  input  wire logic       counterWaitStatus,
  output logic            alarmMatchEnable,
  output logic            counterWaitRequest,
  output logic            clockCalendarIrq,
  output logic            irqOut
);
  rtc_alarm_pkg::bus_req_t req;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [1:0] mask_reg;
  logic [1:0] mask_next;
  logic       pendMatch_reg;
  logic       pendMatch_next;
  logic       calIrq_reg;
  logic       calIrq_next;
  logic       irq_reg;
  logic       irq_next;
  logic       detected;
  logic       periodic;
  logic       detSet;
  logic       detClr;
  logic       perClr;
  logic [1:0] evtStatus;
  logic [1:0] evtSet;
  logic [1:0] evtClr;
  logic [1:0] evtFlag;

  function automatic logic hit(input logic [19:0] a, input logic [19:0] target);
    hit = (a == target);
  endfunction : hit

  // Write decode shared by the control register, the mask and every flag clear.
  function automatic logic wrHit(input rtc_alarm_pkg::bus_req_t r, input logic [19:0] target);
    wrHit = r.wr && hit(r.addr, target);
  endfunction : wrHit

  assign req.addr  = busAddr;
  assign req.wdata = busWdata;
  assign req.wmask = busWmask;
  assign req.wr    = busWrite;
  assign req.rd    = busRead;

  // A match seen with matching disabled is dropped; the pending stage models the
  // one operating clock delay, so the set lands on the next calendar tick.
  always_comb
  begin
    pendMatch_next = pendMatch_reg;
    if (!ctrl_reg[rtc_alarm_pkg::BIT_MATCH_EN])
      pendMatch_next = 1'b0;
    else if (alarmMatch)
      pendMatch_next = 1'b1;
    else if (calendarTick)
      pendMatch_next = 1'b0;
  end

  assign detSet = pendMatch_reg && calendarTick && ctrl_reg[rtc_alarm_pkg::BIT_MATCH_EN];

  // Writing zero to a flag bit clears it; writing one leaves it untouched.
  assign detClr = wrHit(req, rtc_alarm_pkg::CTRL_ONE_ADDR)
                  && req.wmask[rtc_alarm_pkg::BIT_DETECTED]
                  && !req.wdata[rtc_alarm_pkg::BIT_DETECTED];
  assign perClr = wrHit(req, rtc_alarm_pkg::CTRL_ONE_ADDR)
                  && req.wmask[rtc_alarm_pkg::BIT_PERIODIC]
                  && !req.wdata[rtc_alarm_pkg::BIT_PERIODIC];

  rtc_flag_cell detectedCell (
    .core_clk (core_clk),
    .srst     (srst),
    .setPulse (detSet),
    .clrPulse (detClr),
    .flag     (detected)
  );

  rtc_flag_cell periodicCell (
    .core_clk (core_clk),
    .srst     (srst),
    .setPulse (periodicEvent),
    .clrPulse (perClr),
    .flag     (periodic)
  );

  assign evtSet[rtc_alarm_pkg::EVT_ALARM]    = detSet && ctrl_reg[rtc_alarm_pkg::BIT_IRQ_EN];
  assign evtSet[rtc_alarm_pkg::EVT_PERIODIC] = periodicEvent;

  // Interrupt status bits are cleared by writing one, per bit.
  genvar gi;
  generate
    for (gi = 0; gi < rtc_alarm_pkg::EVT_W; gi++)
    begin : gEvt
      assign evtClr[gi] = wrHit(req, rtc_alarm_pkg::IRQ_STATUS_ADDR)
                          && req.wmask[gi] && req.wdata[gi];
      rtc_flag_cell evtCell (
        .core_clk (core_clk),
        .srst     (srst),
        .setPulse (evtSet[gi]),
        .clrPulse (evtClr[gi]),
        .flag     (evtFlag[gi])
      );
    end
  endgenerate

  assign evtStatus = evtFlag;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    if (wrHit(req, rtc_alarm_pkg::CTRL_ONE_ADDR))
      ctrl_next = (ctrl_reg & ~req.wmask) | (req.wdata & req.wmask);
    if (wrHit(req, rtc_alarm_pkg::IRQ_MASK_ADDR))
      mask_next = (mask_reg & ~req.wmask[1:0]) | (req.wdata[1:0] & req.wmask[1:0]);
    // Flag and status positions are not stored here; the flags live in the flag cells, the wait status comes from counterWaitStatus.
    ctrl_next[rtc_alarm_pkg::BIT_DETECTED]  = 1'b0;
    ctrl_next[rtc_alarm_pkg::BIT_PERIODIC]  = 1'b0;
    ctrl_next[rtc_alarm_pkg::BIT_WAIT_STAT] = 1'b0;
    ctrl_next = ctrl_next & ~rtc_alarm_pkg::CTRL_FIXED_ZERO;
  end

  always_comb
  begin
    rdata_next = 8'h00;
    if (req.rd)
    begin
      if (hit(req.addr, rtc_alarm_pkg::CTRL_ONE_ADDR))
      begin
        rdata_next = ctrl_reg & ~rtc_alarm_pkg::CTRL_FIXED_ZERO;
        rdata_next[rtc_alarm_pkg::BIT_DETECTED]  = detected;
        rdata_next[rtc_alarm_pkg::BIT_PERIODIC]  = periodic;
        rdata_next[rtc_alarm_pkg::BIT_WAIT_STAT] = counterWaitStatus;
      end
      else if (hit(req.addr, rtc_alarm_pkg::IRQ_STATUS_ADDR))
        rdata_next = {6'h00, evtStatus};
      else if (hit(req.addr, rtc_alarm_pkg::IRQ_MASK_ADDR))
        rdata_next = {6'h00, mask_reg};
    end
  end

  // The calendar interrupt pulses for each enabled alarm detection.
  always_comb
  begin
    calIrq_next = evtSet[rtc_alarm_pkg::EVT_ALARM];
    irq_next    = |(evtStatus & mask_reg);
  end

  // A reset in mid-run drops a pending match too, so no stale detection can
  // land on the first calendar tick after the reset is released.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      pendMatch_reg <= 1'b0;
    else
      pendMatch_reg <= pendMatch_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ctrl_reg <= rtc_alarm_pkg::CTRL_RESET;
      mask_reg <= rtc_alarm_pkg::EVT_RESET;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
    end
  end

  // Read data return to zero after one cycle, so a stale value can never be
  // taken for the answer to a later read.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      calIrq_reg <= 1'b0;
      irq_reg    <= 1'b0;
    end
    else
    begin
      calIrq_reg <= calIrq_next;
      irq_reg    <= irq_next;
    end
  end

  assign busRdata           = rdata_reg;
  assign alarmMatchEnable   = ctrl_reg[rtc_alarm_pkg::BIT_MATCH_EN];
  assign counterWaitRequest = ctrl_reg[rtc_alarm_pkg::BIT_WAIT_REQ];
  assign clockCalendarIrq   = calIrq_reg;
  assign irqOut             = irq_reg;
endmodule : rtc_alarm_control

// ---- tb/rtc_alarm_control_monitor.sv ----
// Port checker of the alarm control block.
`timescale 1ns/10ps
module rtc_alarm_control_monitor (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic [19:0] busAddr,
  input wire logic [7:0]  busWdata,
  input wire logic [7:0]  busWmask,
  input wire logic        busWrite,
  input wire logic        busRead,
  input wire logic [7:0]  busRdata,
  input wire logic        alarmMatchEnable,
  input wire logic        counterWaitRequest,
  input wire logic        clockCalendarIrq
);
  wire logic ctrlWr  = busWrite && busAddr == rtc_alarm_pkg::CTRL_ONE_ADDR;
  wire logic ctrlRd  = busRead && busAddr == rtc_alarm_pkg::CTRL_ONE_ADDR;
  wire logic otherRd = busRead && busAddr != rtc_alarm_pkg::CTRL_ONE_ADDR
    && busAddr != rtc_alarm_pkg::IRQ_STATUS_ADDR && busAddr != rtc_alarm_pkg::IRQ_MASK_ADDR;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_reset_clear: assert property (disable iff (1'b0) srst |=> !alarmMatchEnable
    && !counterWaitRequest && !clockCalendarIrq) else $error("reset left outputs set");
  a_rdata_idle: assert property (!busRead |=> busRdata == 8'h00)
    else $error("read data outside read slot");
  a_fixed_zero: assert property (ctrlRd |=> (busRdata & rtc_alarm_pkg::CTRL_FIXED_ZERO) == 8'h00)
    else $error("fixed bits read as one");
  a_unmapped_read: assert property (otherRd |=> busRdata == 8'h00)
    else $error("unmapped read not zero");
  a_match_write: assert property (ctrlWr && busWmask[7] |=>
    alarmMatchEnable == $past(busWdata[7])) else $error("match enable not written");
  a_wait_hold: assert property (!(ctrlWr && busWmask[0]) |=> $stable(counterWaitRequest))
    else $error("wait request changed without write");
  a_irq_pulse: assert property (clockCalendarIrq |=> !clockCalendarIrq)
    else $error("alarm irq longer than one cycle");
  a_irq_gated: assert property (!alarmMatchEnable [*4] |-> !clockCalendarIrq)
    else $error("alarm irq while matching off");
endmodule : rtc_alarm_control_monitor

bind rtc_alarm_control rtc_alarm_control_monitor u_mon (.core_clk(core_clk), .srst(srst),
  .busAddr(busAddr), .busWdata(busWdata), .busWmask(busWmask), .busWrite(busWrite),
  .busRead(busRead), .busRdata(busRdata), .alarmMatchEnable(alarmMatchEnable),
  .counterWaitRequest(counterWaitRequest), .clockCalendarIrq(clockCalendarIrq));

// ---- tb/rtc_alarm_control_tb_top.sv ----
// Register-level bench of the alarm control block.
`timescale 1ns/10ps
module rtc_alarm_control_tb_top;
  localparam logic [19:0] CTRL = rtc_alarm_pkg::CTRL_ONE_ADDR;
  localparam logic [19:0] STAT = rtc_alarm_pkg::IRQ_STATUS_ADDR;
  localparam logic [19:0] MASK = rtc_alarm_pkg::IRQ_MASK_ADDR;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic [19:0] busAddr = 20'h00000;
  logic [7:0]  busWdata = 8'h00;
  logic [7:0]  busWmask = 8'h00;
  logic        busWrite = 1'b0;
  logic        busRead = 1'b0;
  logic [7:0]  busRdata;
  logic        alarmMatch = 1'b0;
  logic        periodicEvent = 1'b0;
  logic        calendarTick = 1'b0;
  logic        counterWaitStatus = 1'b0;
  logic        alarmMatchEnable;
  logic        counterWaitRequest;
  logic        clockCalendarIrq;
  logic        irqOut;
  int          err_total = 0;
  int          checks_done = 0;
  rtc_alarm_control u_dut (.core_clk(core_clk), .srst(srst), .busAddr(busAddr),
    .busWdata(busWdata), .busWmask(busWmask), .busWrite(busWrite), .busRead(busRead),
    .busRdata(busRdata), .alarmMatch(alarmMatch), .periodicEvent(periodicEvent),
    .calendarTick(calendarTick), .counterWaitStatus(counterWaitStatus),
    .alarmMatchEnable(alarmMatchEnable), .counterWaitRequest(counterWaitRequest),
    .clockCalendarIrq(clockCalendarIrq), .irqOut(irqOut));
  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic [7:0] m);
    busAddr <= a;
    busWdata <= d;
    busWmask <= m;
    busWrite <= 1'b1;
    @(posedge core_clk);
    busWrite <= 1'b0;
    // An idle edge follows, so a strobe is never lowered and raised in one step.
    @(posedge core_clk);
  endtask : wr
  // Read data stand only in the cycle after the strobe, so it is sampled there.
  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge core_clk);
    busRead <= 1'b0;
    #1 chk(busRdata, e);
    @(posedge core_clk);
  endtask : rd
  task automatic alarm(input logic [7:0] expIrq);
    logic [7:0] n;
    n = 8'h00;
    alarmMatch <= 1'b1;
    @(posedge core_clk);
    alarmMatch <= 1'b0;
    calendarTick <= 1'b1;
    @(posedge core_clk);
    calendarTick <= 1'b0;
    // The alarm pulse stands in the cycle right after the tick edge, so counting starts there.
    repeat (4)
    begin
      #1 n = n + {7'h00, clockCalendarIrq === 1'b1};
      @(posedge core_clk);
    end
    chk(n, expIrq);
  endtask : alarm
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(CTRL, 8'h00);
    wr(CTRL, 8'hFF, 8'hFF);
    chk({6'h00, alarmMatchEnable, counterWaitRequest}, 8'h03);
    rd(CTRL, 8'hC1);
    wr(CTRL, 8'h00, 8'h80);
    rd(CTRL, 8'h41);
    wr(CTRL, 8'h00, 8'hFF);
    alarm(8'h00);
    rd(CTRL, 8'h00);
    $display("test registers done");
    wr(CTRL, 8'h40, 8'hFF);
    wr(CTRL, 8'hC0, 8'hFF);
    wr(STAT, 8'h01, 8'hFF);
    wr(MASK, 8'h01, 8'hFF);
    alarm(8'h01);
    chk({7'h00, irqOut}, 8'h01);
    rd(CTRL, 8'hD0);
    rd(STAT, 8'h01);
    wr(CTRL, 8'hFF, 8'h10);
    rd(CTRL, 8'hD0);
    wr(CTRL, 8'h00, 8'h10);
    rd(CTRL, 8'hC0);
    wr(MASK, 8'h00, 8'hFF);
    wr(CTRL, 8'h00, 8'h80);
    wr(CTRL, 8'h00, 8'h40);
    wr(CTRL, 8'h80, 8'h80);
    wr(CTRL, 8'h00, 8'h10);
    wr(STAT, 8'h01, 8'hFF);
    wr(MASK, 8'h03, 8'hFF);
    alarm(8'h00);
    rd(CTRL, 8'h90);
    rd(STAT, 8'h00);
    chk({7'h00, irqOut}, 8'h00);
    $display("test alarm done");
    counterWaitStatus <= 1'b1;
    periodicEvent <= 1'b1;
    @(posedge core_clk);
    periodicEvent <= 1'b0;
    rd(CTRL, 8'h9A);
    rd(STAT, 8'h02);
    chk({7'h00, irqOut}, 8'h01);
    rd(20'h00000, 8'h00);
    wr(STAT, 8'hFF, 8'hFF);
    repeat (2) @(posedge core_clk);
    #1 chk({7'h00, irqOut}, 8'h00);
    @(posedge core_clk);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    chk({6'h00, alarmMatchEnable, counterWaitRequest}, 8'h00);
    rd(CTRL, 8'h02);
    rd(STAT, 8'h00);
    $display("test status done");
    wrap_up();
  end
endmodule : rtc_alarm_control_tb_top
